//--- core/ospt_channel.sv
// One-shot pulse timer channel: period counter, period and duty compare, one-shot
// launch, continuous pulse and serial shift output, compare triggers and interrupt.
// Assumes a plain register port with read data one cycle after the read strobe,
// a previous-channel trigger from logic on core_clk and a capture event from a pin.
`timescale 1ns/1ps
`default_nettype none

module ospt_channel
    import ospt_pkg::*;
#(
    parameter int unsigned CNT_W = OSPT_CNT_W
) (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire logic [OSPT_ADDR_W-1:0] reg_addr,
    input  wire logic [OSPT_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output var  logic [OSPT_DATA_W-1:0] reg_rdata,
    input  wire logic                   previous_channel_trigger,
    input  wire logic                   external_capture_event,
    output var  logic                   channel_out,
    output var  logic                   first_compare_trigger,
    output var  logic                   second_compare_trigger,
    output var  logic                   irq
);

    // State fields, all registered together:
    //   phase          - where the channel is in its cycle
    //   ctrl           - control word as last written
    //   period_counter - counts selected clock enables
    //   period_compare - period length, or shift count
    //   duty_compare   - pulse length, or shift pattern
    //   shreg          - rotating shift pattern
    //   notify         - sticky compare flags
    //   mask           - interrupt enables per flag
    //   div            - free-running divide-by-16 count
    //   tick           - registered clock enable
    //   cap_s1, cap_s2 - capture pin synchroniser
    //   cap_prev       - last synchronised capture level
    //   ext_pend       - counter reset waiting for tick
    //   launch_pend    - chain or capture launch waiting
    //   active         - output level before polarity
    //   pin            - output after polarity
    //   trig0, trig1   - one-cycle compare triggers
    //   irq, rdata     - interrupt and read answer
    // Keeping everything in one struct lets reset and
    // the register update stay in a single clocked block.

    typedef struct packed {
        ospt_phase_t             phase;
        logic [OSPT_CTRL_W-1:0]  ctrl;
        logic [CNT_W-1:0]        period_counter;
        logic [CNT_W-1:0]        period_compare;
        logic [CNT_W-1:0]        duty_compare;
        logic [CNT_W-1:0]        shreg;
        logic [1:0]              notify;
        logic [1:0]              mask;
        logic [3:0]              div;
        logic                    tick;
        logic                    cap_s1;
        logic                    cap_s2;
        logic                    cap_prev;
        logic                    ext_pend;
        logic                    launch_pend;
        logic                    active;
        logic                    pin;
        logic                    trig0;
        logic                    trig1;
        logic                    irq;
        logic [OSPT_DATA_W-1:0]  rdata;
    } ospt_state_t;

    ospt_state_t st_ff;
    ospt_state_t nxt_st;

    // Every output is a plain copy of a state field
    assign reg_rdata              = st_ff.rdata;
    assign channel_out            = st_ff.pin;
    assign first_compare_trigger  = st_ff.trig0;
    assign second_compare_trigger = st_ff.trig1;
    assign irq                    = st_ff.irq;

    // Phase flow:
    //   IDLE  - counter held at zero, output inactive
    //   INIT  - one-shot lead-in, output held inactive
    //   PULSE - one-shot pulse, ends back in IDLE
    //   RUN   - continuous pulses, one per period
    //   SHIFT - serial output, one bit per tick
    // A one-shot starts from a counter write or, with
    // chain start set, from the previous channel or the
    // capture pin. Chain and capture launches wait for
    // the next tick, so the lead-in always begins on a
    // clean enable boundary.
    // Both compares run in INIT as well, so triggers
    // and flags appear there even though the output
    // stays inactive; software that counts interrupts
    // must expect them.
    // The capture counter reset never acts at once: it
    // is parked in ext_pend until the selected enable,
    // which keeps compare values of zero and one exact
    // on a divided clock.

    always_comb begin
        logic             en;
        logic             oneshot;
        logic             serial;
        logic             cap_edge;
        logic             match0;
        logic             match1;
        logic             duty_on;
        logic [CNT_W-1:0] cmp0_m1;
        logic [1:0]       clr;
        logic [1:0]       upd;
        en       = st_ff.ctrl[OSPT_B_EN];
        oneshot  = st_ff.ctrl[OSPT_B_ONESHOT];
        serial   = st_ff.ctrl[OSPT_B_SERIAL];
        upd      = st_ff.ctrl[OSPT_B_UPD_HI:OSPT_B_UPD_LO];
        cap_edge = st_ff.cap_s2 & ~st_ff.cap_prev;
        // A zero period compare behaves as one so that the counter never wraps
        cmp0_m1  = (st_ff.period_compare == '0) ? '0 : st_ff.period_compare - 1'b1;
        match0   = (st_ff.period_counter == cmp0_m1);
        // A zero duty compare means no active level at all
        duty_on  = (st_ff.duty_compare != '0);
        match1   = duty_on & (st_ff.period_counter == st_ff.duty_compare - 1'b1);
        clr      = 2'h0;

        nxt_st       = st_ff;
        nxt_st.trig0 = 1'b0;
        nxt_st.trig1 = 1'b0;

        // Divider and enable run even while disabled, so
        // the first tick after enabling is never late by
        // more than one divided period.
        // Free-running divider; enable is registered, so counting lags selection by one cycle
        nxt_st.div  = st_ff.div + 1'b1;
        nxt_st.tick = st_ff.ctrl[OSPT_B_FXSEL] ? (st_ff.div == OSPT_DIV_LAST) : 1'b1;

        // Two flops before the edge detector; only the
        // second stage feeds any decision.
        nxt_st.cap_s1   = external_capture_event;
        nxt_st.cap_s2   = st_ff.cap_s1;
        nxt_st.cap_prev = st_ff.cap_s2;

        // Requests wait for the clock enable; a new request in the consuming cycle survives
        nxt_st.ext_pend = (st_ff.ext_pend & ~st_ff.tick)
                        | (cap_edge & st_ff.ctrl[OSPT_B_EXTSEL] & st_ff.ctrl[OSPT_B_RSTCMP]);
        nxt_st.launch_pend = (st_ff.launch_pend & ~st_ff.tick)
                           | (oneshot & st_ff.ctrl[OSPT_B_CHAIN]
                              & (previous_channel_trigger | (cap_edge & st_ff.ctrl[OSPT_B_EXTSEL])));

        // Clearing enable drops every pending request so a
        // stale capture cannot start a pulse on re-enable.

        if (!en) begin
            nxt_st.phase       = OSPT_IDLE;
            nxt_st.active      = 1'b0;
            nxt_st.ext_pend    = 1'b0;
            nxt_st.launch_pend = 1'b0;
        end else if (st_ff.tick) begin
            // Launch beats a capture reset on the same tick
            if (st_ff.launch_pend && !serial) begin
                nxt_st.period_counter = '0;
                nxt_st.phase          = OSPT_INIT;
                nxt_st.active         = 1'b0;
            end else begin
                case (st_ff.phase)
                    OSPT_IDLE: begin
                        nxt_st.period_counter = '0;
                        if (serial) begin
                            nxt_st.phase = OSPT_SHIFT;
                            nxt_st.shreg = st_ff.duty_compare;
                        end else if (!oneshot) begin
                            nxt_st.phase  = OSPT_RUN;
                            nxt_st.active = duty_on;
                        end
                    end
                    // Compare handling shared by the three
                    // counting phases; a pending capture reset
                    // wins over a match on the same tick.
                    OSPT_INIT, OSPT_PULSE, OSPT_RUN: begin
                        if (st_ff.ext_pend) begin
                            // Reset lands on the enable, so a new period starts cleanly
                            nxt_st.period_counter = '0;
                            if (st_ff.phase != OSPT_INIT) begin
                                nxt_st.active = duty_on;
                            end
                        end else begin
                            nxt_st.trig0 = match0;
                            nxt_st.trig1 = match1;
                            if (match0) begin
                                nxt_st.period_counter = '0;
                                if (st_ff.phase == OSPT_PULSE) begin
                                    nxt_st.phase  = OSPT_IDLE;
                                    nxt_st.active = 1'b0;
                                end else begin
                                    nxt_st.phase  = (st_ff.phase == OSPT_INIT) ? OSPT_PULSE : OSPT_RUN;
                                    nxt_st.active = duty_on;
                                end
                            end else begin
                                nxt_st.period_counter = st_ff.period_counter + 1'b1;
                                if (match1 && st_ff.phase != OSPT_INIT) begin
                                    nxt_st.active = 1'b0;
                                end
                            end
                            if (st_ff.phase == OSPT_INIT) begin
                                nxt_st.active = match0 & duty_on;
                            end
                        end
                    end
                    // Serial output: the MSB goes out and the
                    // pattern rotates on every tick. At the end
                    // of the count a reload happens only with
                    // reload update on; otherwise shifting just
                    // carries on, so the line never stalls.
                    // Counts above 23 are a software mistake
                    // and are not trapped here.
                    OSPT_SHIFT: begin
                        nxt_st.active = st_ff.shreg[CNT_W-1];
                        nxt_st.shreg  = {st_ff.shreg[CNT_W-2:0], st_ff.shreg[CNT_W-1]};
                        if (st_ff.ext_pend) begin
                            nxt_st.period_counter = '0;
                        end else if (st_ff.period_counter == st_ff.period_compare) begin
                            nxt_st.trig0          = 1'b1;
                            nxt_st.period_counter = '0;
                            if (upd != OSPT_UPD_OFF) begin
                                nxt_st.shreg = st_ff.duty_compare;
                            end
                        end else begin
                            nxt_st.period_counter = st_ff.period_counter + 1'b1;
                        end
                    end
                    default: begin
                        nxt_st.phase = OSPT_IDLE;
                    end
                endcase
            end
        end

        // Register writes come last so they win over the
        // tick update of the same cycle. Map:
        //   CTRL  - enable, one-shot, chain start, capture
        //           select, capture reset, serial, reload
        //           update, clock index, active level
        //   PCNT  - period counter, write launches a
        //           one-shot when chain start is clear
        //   PCMP  - period compare, shift count in serial
        //   DCMP  - duty compare, shift pattern in serial
        //   ISTAT - sticky flags, cleared by reading
        //   IMASK - interrupt enables
        //   PHASE - read-only phase and active level
        // Unmapped offsets are ignored; the bus never
        // waits.

        if (reg_wr) begin
            if (reg_addr == OSPT_OFS_CTRL) begin
                nxt_st.ctrl = reg_wdata[OSPT_CTRL_W-1:0];
            end else if (reg_addr == OSPT_OFS_PCNT) begin
                nxt_st.period_counter = reg_wdata[CNT_W-1:0];
                if (en && oneshot && !serial && !st_ff.ctrl[OSPT_B_CHAIN]) begin
                    // Each write restarts the initial phase from the written count
                    nxt_st.phase  = OSPT_INIT;
                    nxt_st.active = 1'b0;
                end
            end else if (reg_addr == OSPT_OFS_PCMP) begin
                nxt_st.period_compare = reg_wdata[CNT_W-1:0];
            end else if (reg_addr == OSPT_OFS_DCMP) begin
                nxt_st.duty_compare = reg_wdata[CNT_W-1:0];
            end else if (reg_addr == OSPT_OFS_IMASK) begin
                nxt_st.mask = reg_wdata[1:0];
            end
        end

        // Read data stands for one cycle only and is zero
        // otherwise, so a bus mux can simply OR slaves.
        // Reading ISTAT clears both flags, but a trigger
        // of the same cycle is kept.

        nxt_st.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == OSPT_OFS_CTRL) begin
                nxt_st.rdata = {{(OSPT_DATA_W-OSPT_CTRL_W){1'b0}}, st_ff.ctrl};
            end else if (reg_addr == OSPT_OFS_PCNT) begin
                nxt_st.rdata = {{(OSPT_DATA_W-CNT_W){1'b0}}, st_ff.period_counter};
            end else if (reg_addr == OSPT_OFS_PCMP) begin
                nxt_st.rdata = {{(OSPT_DATA_W-CNT_W){1'b0}}, st_ff.period_compare};
            end else if (reg_addr == OSPT_OFS_DCMP) begin
                nxt_st.rdata = {{(OSPT_DATA_W-CNT_W){1'b0}}, st_ff.duty_compare};
            end else if (reg_addr == OSPT_OFS_ISTAT) begin
                nxt_st.rdata = {{(OSPT_DATA_W-2){1'b0}}, st_ff.notify};
                clr          = 2'h3;
            end else if (reg_addr == OSPT_OFS_IMASK) begin
                nxt_st.rdata = {{(OSPT_DATA_W-2){1'b0}}, st_ff.mask};
            end else if (reg_addr == OSPT_OFS_PHASE) begin
                nxt_st.rdata = {{(OSPT_DATA_W-4){1'b0}}, st_ff.active, st_ff.phase};
            end
        end

        // A trigger in the same cycle as the clearing read stays set
        nxt_st.notify = (st_ff.notify & ~clr) | {nxt_st.trig1, nxt_st.trig0};
        nxt_st.irq    = |(nxt_st.notify & st_ff.mask);

        // Polarity is applied last, from the current
        // control word, so a level change shows two
        // cycles after the write that makes it.
        nxt_st.pin    = nxt_st.active ? st_ff.ctrl[OSPT_B_LEVEL] : ~st_ff.ctrl[OSPT_B_LEVEL];
    end

    // Synchronous reset only: every field goes to a
    // constant, with the output at its inactive level
    // for the reset polarity so no glitch leaves the
    // pin when reset releases.

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff             <= '0;
            st_ff.phase       <= OSPT_IDLE;
            st_ff.ctrl        <= OSPT_CTRL_RST;
            st_ff.notify      <= OSPT_IRQ_RST;
            st_ff.mask        <= OSPT_IRQ_RST;
            st_ff.pin         <= ~OSPT_CTRL_RST[OSPT_B_LEVEL];
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : ospt_channel

`default_nettype wire

//--- core/ospt_pkg.sv
// Package for the one-shot pulse timer channel: register map, control field layout,
// reset values, divider constant and the channel phase encoding.
// Assumes a 32-bit plain register port with byte offsets on word boundaries.
package ospt_pkg;

    localparam int unsigned OSPT_ADDR_W      = 8;
    localparam int unsigned OSPT_DATA_W      = 32;
    localparam int unsigned OSPT_CNT_W       = 24;

    localparam logic [7:0]  OSPT_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OSPT_OFS_PCNT    = 8'h04;
    localparam logic [7:0]  OSPT_OFS_PCMP    = 8'h08;
    localparam logic [7:0]  OSPT_OFS_DCMP    = 8'h0c;
    localparam logic [7:0]  OSPT_OFS_ISTAT   = 8'h10;
    localparam logic [7:0]  OSPT_OFS_IMASK   = 8'h14;
    localparam logic [7:0]  OSPT_OFS_PHASE   = 8'h18;

    localparam int unsigned OSPT_CTRL_W      = 10;
    localparam int unsigned OSPT_B_EN        = 0;
    localparam int unsigned OSPT_B_ONESHOT   = 1;
    localparam int unsigned OSPT_B_CHAIN     = 2;
    localparam int unsigned OSPT_B_EXTSEL    = 3;
    localparam int unsigned OSPT_B_RSTCMP    = 4;
    localparam int unsigned OSPT_B_SERIAL    = 5;
    localparam int unsigned OSPT_B_UPD_LO    = 6;
    localparam int unsigned OSPT_B_UPD_HI    = 7;
    localparam int unsigned OSPT_B_FXSEL     = 8;
    localparam int unsigned OSPT_B_LEVEL     = 9;

    localparam logic [9:0]  OSPT_CTRL_RST    = 10'h200;
    localparam logic [1:0]  OSPT_UPD_OFF     = 2'h0;
    localparam logic [1:0]  OSPT_IRQ_RST     = 2'h0;
    localparam int unsigned OSPT_B_IRQ_CMP0  = 0;
    localparam int unsigned OSPT_B_IRQ_CMP1  = 1;

    // Fixed clock enable index one divides the core clock by sixteen
    localparam int unsigned OSPT_FX1_DIV     = 16;
    localparam logic [3:0]  OSPT_DIV_LAST    = 4'(OSPT_FX1_DIV - 1);

    typedef enum logic [2:0] {
        OSPT_IDLE,
        OSPT_INIT,
        OSPT_PULSE,
        OSPT_RUN,
        OSPT_SHIFT
    } ospt_phase_t;

endpackage : ospt_pkg

//--- verification/ospt_far_end.sv
// Far-side model: previous channel chain trigger and capture input pin.
// Assumes one-cycle commands from the bench, issued on core_clk.
`timescale 1ns/1ps
`default_nettype none

module ospt_far_end (
    input  wire logic core_clk,
    input  wire logic fire_chain,
    input  wire logic fire_cap,
    output var  logic previous_channel_trigger,
    output var  logic external_capture_event
);
    logic [2:0] hold_ff = 3'h0;

    initial begin
        previous_channel_trigger = 1'b0;
        external_capture_event   = 1'b0;
    end

    // Pin stays high a few cycles so the two-stage sync cannot miss it
    always @(posedge core_clk) begin
        previous_channel_trigger <= fire_chain;
        hold_ff                  <= fire_cap ? 3'h4 : hold_ff - 3'(hold_ff != 3'h0);
        external_capture_event   <= fire_cap | (hold_ff > 3'h1);
    end
endmodule : ospt_far_end

`default_nettype wire

//--- verification/ospt_channel_properties.sv
// Port-level checker for the one-shot pulse timer channel.
// Shadows control, mask and whether period compare exceeds one from the register port writes.
`timescale 1ns/1ps
`default_nettype none

module ospt_channel_properties
    import ospt_pkg::*;
(
    input wire logic                   core_clk,
    input wire logic                   sys_rst,
    input wire logic [OSPT_ADDR_W-1:0] reg_addr,
    input wire logic [OSPT_DATA_W-1:0] reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [OSPT_DATA_W-1:0] reg_rdata,
    input wire logic                   channel_out,
    input wire logic                   first_compare_trigger,
    input wire logic                   second_compare_trigger,
    input wire logic                   irq
);
    logic [9:0] ctl_ff;
    logic [1:0] msk_ff;
    logic       long_ff;
    logic       any_trig;
    logic       osp;

    assign any_trig = first_compare_trigger | second_compare_trigger;
    // Capture counter reset restarts a period without a trigger, so it is excluded
    assign osp      = ctl_ff[OSPT_B_ONESHOT] & ~ctl_ff[OSPT_B_SERIAL] & ~ctl_ff[OSPT_B_RSTCMP];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_ff  <= OSPT_CTRL_RST;
            msk_ff  <= OSPT_IRQ_RST;
            long_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == OSPT_OFS_CTRL) ctl_ff <= reg_wdata[9:0];
            if (reg_addr == OSPT_OFS_IMASK) msk_ff <= reg_wdata[1:0];
            if (reg_addr == OSPT_OFS_PCMP) long_ff <= reg_wdata[23:0] > 24'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_RDATA_ONLY_AFTER_READ: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside the read answer cycle");
    AST_IRQ_ON_TRIGGER: assert property (first_compare_trigger && msk_ff[0] && !reg_wr |-> ##[1:3] irq)
        else $error("enabled compare trigger raised no interrupt");
    AST_IRQ_RISE_CAUSE: assert property ($rose(irq) |-> any_trig || $past(any_trig)
        || $past(any_trig, 2) || $past(any_trig, 3) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt rose without a trigger");
    AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |-> $past(reg_rd) || $past(reg_rd, 2)
        || $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt fell without a clear");
    AST_TRIG0_GAP: assert property (first_compare_trigger && long_ff && !reg_wr && !$past(reg_wr)
        |=> !first_compare_trigger)
        else $error("period trigger on consecutive cycles");
    AST_DIVIDED_GAP: assert property (any_trig && ctl_ff[OSPT_B_FXSEL] && !$past(reg_wr)
        |=> !any_trig [*8])
        else $error("triggers closer than the divided tick");
    AST_ACTIVE_AT_MATCH: assert property (osp && $changed(channel_out) && !$past(reg_wr)
        && !$past(reg_wr, 2) && channel_out == ctl_ff[OSPT_B_LEVEL] |-> first_compare_trigger)
        else $error("active edge without period match");
    AST_INACTIVE_AT_MATCH: assert property (osp && $changed(channel_out) && !$past(reg_wr)
        && !$past(reg_wr, 2) && channel_out != ctl_ff[OSPT_B_LEVEL] |-> any_trig)
        else $error("inactive edge without compare match");

    cover property (first_compare_trigger && ctl_ff[OSPT_B_FXSEL]);
    cover property ($rose(irq));
    cover property (first_compare_trigger && ctl_ff[OSPT_B_SERIAL]);
endmodule : ospt_channel_properties

bind ospt_channel ospt_channel_properties u_ospt_channel_properties (.core_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .channel_out, .first_compare_trigger,
    .second_compare_trigger, .irq);

`default_nettype wire

//--- verification/one_shot_pulse_timer_channel_bench.sv
// Self-checking bench for the one-shot pulse timer channel.
// Assumes the far-side model drives the chain trigger and the capture pin.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module one_shot_pulse_timer_channel_bench;
    import ospt_pkg::*;
    logic        core_clk, sys_rst, reg_wr, reg_rd, fire_chain, fire_cap;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic        prev_trig, cap_evt, channel_out, trig0, trig1, irq;
    int          miscompares = 0;
    int          checks = 0;

    ospt_channel u_ospt_channel (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .previous_channel_trigger(prev_trig), .external_capture_event(cap_evt),
        .channel_out, .first_compare_trigger(trig0), .second_compare_trigger(trig1), .irq);
    ospt_far_end u_ospt_far_end (.core_clk, .fire_chain, .fire_cap,
        .previous_channel_trigger(prev_trig), .external_capture_event(cap_evt));

    task automatic summarize;
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // Idle cycle after each strobe keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        @(posedge core_clk);
    endtask : rd

    // Launch (0 counter write, 1 chain, 2 capture), then time triggers and pulse
    task automatic shot(input int mode, input logic [23:0] c, input int n,
                        output int t0, output int t1, output int w, output int n1);
        t0 = -1;
        t1 = -1;
        w  = 0;
        n1 = 0;
        // The counter write edge is cycle zero, so a short lead-in is not missed
        reg_addr   <= OSPT_OFS_PCNT;
        reg_wdata  <= {8'h00, c};
        reg_wr     <= (mode == 0);
        fire_chain <= (mode == 1);
        fire_cap   <= (mode == 2);
        @(posedge core_clk);
        reg_wr     <= 1'b0;
        fire_chain <= 1'b0;
        fire_cap   <= 1'b0;
        for (int i = 0; i < n; i++) begin
            #1;
            if (trig0 === 1'b1 && t0 < 0) t0 = i;
            if (trig1 === 1'b1 && t1 < 0) t1 = i;
            n1 += int'(trig1 === 1'b1);
            w  += int'(channel_out === 1'b1);
            @(posedge core_clk);
        end
    endtask : shot

    task automatic s_oneshot;
        int t0, t1, w, n1, u0, u1;
        rd(OSPT_OFS_ISTAT);
        `CHK(v, 32'h0)
        rd(8'h1c);
        `CHK(v, 32'h0)
        wr(OSPT_OFS_PCMP, 32'h5);
        wr(OSPT_OFS_DCMP, 32'h3);
        wr(OSPT_OFS_IMASK, 32'h3);
        wr(OSPT_OFS_CTRL, 32'h203);
        shot(0, 24'h0, 30, t0, t1, w, n1);
        `CHK(t0 - t1, 2)
        `CHK(w, 3)
        `CHK(irq, 1'b1)
        rd(OSPT_OFS_ISTAT);
        `CHK(v, 32'h3)
        #1;
        `CHK(irq, 1'b0)
        @(posedge core_clk);
        shot(0, 24'h1, 30, u0, u1, w, n1);
        `CHK(t0 - u0, 1)
        shot(0, 24'h4, 30, u0, u1, w, n1);
        `CHK(t0 - u0, 4)
        wr(OSPT_OFS_PCNT, 32'h0);
        shot(0, 24'h2, 30, u0, u1, w, n1);
        `CHK(u0 - u1, 2)
    endtask : s_oneshot

    task automatic s_chain;
        int t0, t1, w, n1;
        wr(OSPT_OFS_DCMP, 32'h1);
        wr(OSPT_OFS_CTRL, 32'h207);
        shot(1, 24'h0, 30, t0, t1, w, n1);
        `CHK(t0 - t1, 4)
        `CHK(w, 1)
        `CHK(n1, 2)
    endtask : s_chain

    task automatic s_capture;
        int t0, t1, w, n1;
        wr(OSPT_OFS_DCMP, 32'h3);
        wr(OSPT_OFS_CTRL, 32'h307);
        shot(2, 24'h0, 200, t0, t1, w, n1);
        `CHK(t0, -1)
        wr(OSPT_OFS_CTRL, 32'h30f);
        shot(2, 24'h0, 200, t0, t1, w, n1);
        `CHK(t0 - t1, 32)
        `CHK(w, 48)
        // Continuous pulses, undivided; capture reset lands on the tick after sync
        wr(OSPT_OFS_CTRL, 32'h0);
        wr(OSPT_OFS_CTRL, 32'h219);
        shot(2, 24'h0, 20, t0, t1, w, n1);
        `CHK(t1, 2)
        `CHK(t0, 9)
    endtask : s_capture

    task automatic s_serial;
        int   s, k;
        logic p;
        s = 0;
        k = 0;
        wr(OSPT_OFS_CTRL, 32'h0);
        wr(OSPT_OFS_PCMP, 32'h3);
        wr(OSPT_OFS_DCMP, 32'haaaaaa);
        wr(OSPT_OFS_PCNT, 32'h0);
        wr(OSPT_OFS_CTRL, 32'h221);
        repeat (8) @(posedge core_clk);
        #1;
        p = channel_out;
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            #1;
            s += int'(channel_out === p);
            k += int'(trig0 === 1'b1);
            p = channel_out;
        end
        `CHK(s, 0)
        `CHK(k, 6)
        @(posedge core_clk);
    endtask : s_serial

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        sys_rst    = 1'b1;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0;
        fire_chain = 1'b0;
        fire_cap   = 1'b0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        s_oneshot();
        s_chain();
        s_capture();
        s_serial();
        summarize();
    end

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
endmodule : one_shot_pulse_timer_channel_bench

`default_nettype wire
